// ---- hw/smpc_axil.sv ----
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a single master; write address and data taken in either order.
`timescale 1ns/100ps
module smpc_axil (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [7:0]       wr_data,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_ok,
	input  wire logic        wr_ok
);
	typedef struct packed {
		logic        aw_have;
		logic        w_have;
		logic [7:0]  awaddr;
		logic [7:0]  wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} smpc_ax_t;
	smpc_ax_t s_q;
	smpc_ax_t s_d;
	assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	always_comb begin
		s_d = s_q;
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_have = 1'b1;
			// Registers are byte wide; lane 0 only
			if (s_axi_wstrb[0])
				s_d.wdata = s_axi_wdata[7:0];
			else
				s_d.wdata = smpc_pkg::SMPC_RST_ZERO;
		end
		if (s_q.aw_have && s_q.w_have) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_ok ? smpc_pkg::SMPC_RESP_OKAY
				: smpc_pkg::SMPC_RESP_SLVERR;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = {24'h000000, rd_data};
			s_d.rresp  = rd_ok ? smpc_pkg::SMPC_RESP_OKAY
				: smpc_pkg::SMPC_RESP_SLVERR;
		end else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign wr_en        = s_q.aw_have && s_q.w_have && !s_q.bvalid;
	assign wr_addr      = s_q.awaddr;
	assign wr_data      = s_q.wdata;
	assign rd_en        = s_axi_arvalid && s_axi_arready;
	assign rd_addr      = s_axi_araddr;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp  = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata  = s_q.rdata;
	assign s_axi_rresp  = s_q.rresp;
endmodule : smpc_axil

// ---- hw/smpc_pin_latch.sv ----
// Pin control hold latch for deep stop.
// Assumes port and peripheral pin controls arrive from the bus clock domain.
`timescale 1ns/100ps
module smpc_pin_latch (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        hold,
	input  wire logic [7:0]  port_out,
	input  wire logic [7:0]  port_dir,
	input  wire logic [7:0]  periph_out,
	input  wire logic [7:0]  periph_dir,
	input  wire logic [7:0]  periph_own,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe
);
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} smpc_pl_t;
	smpc_pl_t s_q;
	smpc_pl_t s_d;
	always_comb begin
		s_d = s_q;
		if (!hold) begin
			// Peripherals not re-enabled fall back to port control
			s_d.out = (periph_own & periph_out) | (~periph_own & port_out);
			s_d.oe  = (periph_own & periph_dir) | (~periph_own & port_dir);
		end
		// Otherwise held from deep stop entry
	end
	always_ff @(posedge aclk) begin
		if (!aresetn && !hold)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign pin_out = s_q.out;
	assign pin_oe  = s_q.oe;
	AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		hold && $past(hold) |-> $stable(pin_out) && $stable(pin_oe))
		else $error("pins changed while latched");
endmodule : smpc_pin_latch

// ---- hw/smpc_pkg.sv ----
// Constants, state codes and register map of the stop mode power controller.
// Assumes a 32-bit AXI4-Lite register port and a 100 MHz bus clock.
package smpc_pkg;
	localparam logic [7:0] SMPC_OFS_SYSOPT = 8'h00;
	localparam logic [7:0] SMPC_OFS_PMC1   = 8'h04;
	localparam logic [7:0] SMPC_OFS_PMC2   = 8'h08;
	localparam logic [7:0] SMPC_OFS_CLK1   = 8'h0C;
	localparam logic [7:0] SMPC_OFS_CLK2   = 8'h10;
	localparam logic [7:0] SMPC_OFS_DBG    = 8'h14;
	localparam logic [7:0] SMPC_OFS_STAT   = 8'h18;
	// Field positions
	localparam int SMPC_B_STOP_INSTR_ENABLE   = 0;
	localparam int SMPC_B_LVD_ENABLE    = 0;
	localparam int SMPC_B_LVD_STOP_ENABLE   = 1;
	localparam int SMPC_B_LVDLOW  = 2;
	localparam int SMPC_B_PPDSEL  = 0;
	localparam int SMPC_B_PARTIAL_POWERDOWN_ACK  = 1;
	localparam int SMPC_B_PARTIAL_POWERDOWN_FLAG    = 2;
	localparam int SMPC_B_IRSTEN  = 0;
	localparam int SMPC_B_IRCKEN  = 1;
	localparam int SMPC_B_ERSTEN  = 0;
	localparam int SMPC_B_ERCKEN  = 1;
	localparam int SMPC_B_RANGE   = 2;
	localparam int SMPC_B_ADACK   = 3;
	localparam int SMPC_B_DBGEN   = 0;
	// Reset values, bus response codes and reset vector
	localparam logic [7:0] SMPC_RST_SYSOPT = 8'h01;
	localparam logic [7:0] SMPC_RST_PMC1   = 8'h05;
	localparam logic [7:0] SMPC_RST_ZERO   = 8'h00;
	localparam logic [1:0] SMPC_RESP_OKAY  = 2'h0;
	localparam logic [1:0] SMPC_RESP_SLVERR = 2'h2;
	localparam logic [15:0] SMPC_RESET_VECTOR = 16'hFFFE;
	typedef enum logic [3:0] {
		SMPC_RUN   = 4'h1,
		SMPC_LIGHT = 4'h2,
		SMPC_DEEP  = 4'h4,
		SMPC_BGND  = 4'h8
	} smpc_mode_t;
endpackage : smpc_pkg

// ---- hw/smpc_top.sv ----
// Stop mode power controller: mode choice, clock and power gating, wake-up.
// Assumes the core pulses stop_exec and the debug logic pulses its commands.
`timescale 1ns/100ps
module smpc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        stop_exec,
	input  wire logic        reset_pin,
	input  wire logic        wake_irq_lvd,
	input  wire logic        wake_irq_adc,
	input  wire logic        wake_irq_sci,
	input  wire logic        wake_irq_pin,
	input  wire logic        dbg_halt_cmd,
	input  wire logic        dbg_cmd_valid,
	input  wire logic        dbg_cmd_status,
	input  wire logic        dbg_cmd_active,
	output logic             dbg_cmd_accept,
	output logic             dbg_cmd_stop_err,
	input  wire logic [7:0]  port_out,
	input  wire logic [7:0]  port_dir,
	input  wire logic [7:0]  periph_out,
	input  wire logic [7:0]  periph_dir,
	input  wire logic [7:0]  periph_own,
	output logic [7:0]       pin_out,
	output logic [7:0]       pin_oe,
	output logic             illegal_op_reset,
	output logic             por_reset,
	output logic [15:0]      reset_vector,
	output logic             periph_clk_en,
	output logic             dbg_clk_en,
	output logic             cpu_clk_en,
	output logic             reg_full_on,
	output logic             core_power_on,
	output logic             ram_standby,
	output logic             adc_run,
	output logic             irc_run,
	output logic             erc_run,
	output logic             lvd_reset_en,
	output logic             lvd_low_trip,
	output logic [3:0]       mode
);
	typedef struct packed {
		smpc_pkg::smpc_mode_t mode;
		logic [7:0] sysopt;
		logic [7:0] pmc1;
		logic [7:0] pmc2;
		logic [7:0] clk1;
		logic [7:0] clk2;
		logic [7:0] dbg;
		logic       lvd_keep;
		logic       dbg_keep;
		logic       hold;
		logic       ill;
		logic       por;
		logic       accept;
		logic       err;
	} smpc_st_t;
	smpc_st_t s_q;
	smpc_st_t s_d;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       rd_en;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       rd_ok;
	logic       wr_ok;
	logic       dbg_on;
	logic       lvd_stop;
	logic       light_irq;
	function automatic logic known(input logic [7:0] a);
		known = (a == smpc_pkg::SMPC_OFS_SYSOPT) || (a == smpc_pkg::SMPC_OFS_PMC1)
			|| (a == smpc_pkg::SMPC_OFS_PMC2) || (a == smpc_pkg::SMPC_OFS_CLK1)
			|| (a == smpc_pkg::SMPC_OFS_CLK2) || (a == smpc_pkg::SMPC_OFS_DBG)
			|| (a == smpc_pkg::SMPC_OFS_STAT);
	endfunction : known
	smpc_axil u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok),
		.wr_ok         (wr_ok)
	);
	smpc_pin_latch u_latch (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.hold       (s_q.hold),
		.port_out   (port_out),
		.port_dir   (port_dir),
		.periph_out (periph_out),
		.periph_dir (periph_dir),
		.periph_own (periph_own),
		.pin_out    (pin_out),
		.pin_oe     (pin_oe)
	);
	assign dbg_on   = s_q.dbg[smpc_pkg::SMPC_B_DBGEN];
	assign lvd_stop = s_q.pmc1[smpc_pkg::SMPC_B_LVD_ENABLE]
		&& s_q.pmc1[smpc_pkg::SMPC_B_LVD_STOP_ENABLE];
	assign light_irq = wake_irq_lvd || wake_irq_adc || wake_irq_sci
		|| wake_irq_pin;
	assign rd_ok = known(rd_addr);
	assign wr_ok = known(wr_addr);
	always_comb begin
		unique case (rd_addr)
			smpc_pkg::SMPC_OFS_SYSOPT: rd_data = s_q.sysopt;
			smpc_pkg::SMPC_OFS_PMC1:   rd_data = s_q.pmc1;
			// Ack bit always reads zero
			smpc_pkg::SMPC_OFS_PMC2:   rd_data = s_q.pmc2
				& ~(8'h01 << smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_ACK);
			smpc_pkg::SMPC_OFS_CLK1:   rd_data = s_q.clk1;
			smpc_pkg::SMPC_OFS_CLK2:   rd_data = s_q.clk2;
			smpc_pkg::SMPC_OFS_DBG:    rd_data = s_q.dbg;
			smpc_pkg::SMPC_OFS_STAT:   rd_data = {4'h0, s_q.mode};
			default:                   rd_data = 8'h00;
		endcase
	end
	always_comb begin
		s_d        = s_q;
		s_d.ill    = 1'b0;
		s_d.por    = 1'b0;
		s_d.accept = 1'b0;
		s_d.err    = 1'b0;
		if (wr_en) begin
			unique case (wr_addr)
				smpc_pkg::SMPC_OFS_SYSOPT: s_d.sysopt = wr_data;
				smpc_pkg::SMPC_OFS_PMC1:   s_d.pmc1   = wr_data;
				smpc_pkg::SMPC_OFS_PMC2: begin
					s_d.pmc2[smpc_pkg::SMPC_B_PPDSEL] =
						wr_data[smpc_pkg::SMPC_B_PPDSEL];
					// Only a one acts; a zero leaves flag and latches
					if (wr_data[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_ACK]) begin
						s_d.pmc2[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_FLAG] = 1'b0;
						s_d.hold = 1'b0;
					end
				end
				smpc_pkg::SMPC_OFS_CLK1:   s_d.clk1 = wr_data;
				smpc_pkg::SMPC_OFS_CLK2:   s_d.clk2 = wr_data;
				smpc_pkg::SMPC_OFS_DBG:    s_d.dbg  = wr_data;
				default: ;
			endcase
		end
		if (dbg_cmd_valid && s_q.mode == smpc_pkg::SMPC_LIGHT) begin
			// Status accesses get an error, no memory access
			s_d.err = dbg_cmd_status;
		end else if (dbg_cmd_valid) begin
			// Background mode takes all types
			s_d.accept = (s_q.mode == smpc_pkg::SMPC_BGND) || !dbg_cmd_active;
		end
		unique case (s_q.mode)
			smpc_pkg::SMPC_RUN: begin
				if (stop_exec) begin
					if (!s_q.sysopt[smpc_pkg::SMPC_B_STOP_INSTR_ENABLE]) begin
						s_d.ill = 1'b1;
					end else if (dbg_on || lvd_stop
						|| !s_q.pmc2[smpc_pkg::SMPC_B_PPDSEL]) begin
						// Light stop when PPDSEL clear, or deep request demoted by debug or LVD stop
						s_d.mode     = smpc_pkg::SMPC_LIGHT;
						s_d.dbg_keep = dbg_on;
						s_d.lvd_keep = lvd_stop;
					end else begin
						s_d.mode = smpc_pkg::SMPC_DEEP;
						s_d.hold = 1'b1;
					end
				end
				if (dbg_halt_cmd && dbg_on)
					s_d.mode = smpc_pkg::SMPC_BGND;
			end
			smpc_pkg::SMPC_LIGHT: begin
				if (reset_pin) begin
					s_d.mode = smpc_pkg::SMPC_RUN;
					s_d.por  = 1'b1;
				end else if (dbg_halt_cmd && s_q.dbg_keep) begin
					s_d.mode = smpc_pkg::SMPC_BGND;
				end else if (light_irq) begin
					s_d.mode = smpc_pkg::SMPC_RUN;
				end
			end
			smpc_pkg::SMPC_DEEP: begin
				if (reset_pin) begin
					// Control state back to reset values, latches kept
					s_d.mode   = smpc_pkg::SMPC_RUN;
					s_d.por    = 1'b1;
					s_d.sysopt = smpc_pkg::SMPC_RST_SYSOPT;
					s_d.pmc1   = smpc_pkg::SMPC_RST_PMC1;
					s_d.clk1   = smpc_pkg::SMPC_RST_ZERO;
					s_d.clk2   = smpc_pkg::SMPC_RST_ZERO;
					s_d.dbg    = smpc_pkg::SMPC_RST_ZERO;
					s_d.pmc2   = smpc_pkg::SMPC_RST_ZERO;
					s_d.pmc2[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_FLAG] = 1'b1;
					// Set wins over an ack write in the same cycle
					s_d.hold   = 1'b1;
				end
			end
			smpc_pkg::SMPC_BGND: begin
				if (!dbg_on)
					s_d.mode = smpc_pkg::SMPC_RUN;
			end
			default: s_d.mode = smpc_pkg::SMPC_RUN;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q        <= '0;
			s_q.mode   <= smpc_pkg::SMPC_RUN;
			s_q.sysopt <= smpc_pkg::SMPC_RST_SYSOPT;
			s_q.pmc1   <= smpc_pkg::SMPC_RST_PMC1;
		end else begin
			s_q <= s_d;
		end
	end
	logic in_stop;
	logic in_light;
	assign in_stop  = (s_q.mode == smpc_pkg::SMPC_LIGHT)
		|| (s_q.mode == smpc_pkg::SMPC_DEEP);
	assign in_light = s_q.mode == smpc_pkg::SMPC_LIGHT;
	assign mode             = s_q.mode;
	assign illegal_op_reset = s_q.ill;
	assign por_reset        = s_q.por;
	assign reset_vector     = smpc_pkg::SMPC_RESET_VECTOR;
	assign periph_clk_en    = !in_stop;
	assign cpu_clk_en       = !in_stop;
	assign dbg_clk_en       = !in_stop || (in_light && s_q.dbg_keep);
	// Regulator stays full for debug or LVD; standby in deep
	assign reg_full_on = !in_stop || (in_light && (s_q.dbg_keep || s_q.lvd_keep));
	assign core_power_on = s_q.mode != smpc_pkg::SMPC_DEEP;
	assign ram_standby   = in_stop;
	assign adc_run = !in_stop || (in_light && s_q.lvd_keep
		&& s_q.clk2[smpc_pkg::SMPC_B_ADACK]);
	assign irc_run = !in_stop || (in_light
		&& s_q.clk1[smpc_pkg::SMPC_B_IRCKEN]
		&& s_q.clk1[smpc_pkg::SMPC_B_IRSTEN]);
	assign erc_run = !in_stop || (in_light
		&& s_q.clk2[smpc_pkg::SMPC_B_ERCKEN]
		&& s_q.clk2[smpc_pkg::SMPC_B_ERSTEN]
		&& (!s_q.clk2[smpc_pkg::SMPC_B_RANGE] || s_q.lvd_keep));
	assign lvd_reset_en     = s_q.pmc1[smpc_pkg::SMPC_B_LVD_ENABLE];
	assign lvd_low_trip     = s_q.pmc1[smpc_pkg::SMPC_B_LVDLOW];
	assign dbg_cmd_accept   = s_q.accept;
	assign dbg_cmd_stop_err = s_q.err;
	sequence s_deep_wake;
		s_q.mode == smpc_pkg::SMPC_DEEP && reset_pin;
	endsequence
	sequence s_ack_write;
		wr_en && wr_addr == smpc_pkg::SMPC_OFS_PMC2
			&& wr_data[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_ACK]
			&& s_q.mode != smpc_pkg::SMPC_DEEP && !stop_exec;
	endsequence
	AST_DEMOTE: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_RUN && stop_exec && s_q.sysopt[0]
		&& (dbg_on || lvd_stop) |=> mode == smpc_pkg::SMPC_LIGHT)
		else $error("deep request not demoted");
	AST_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_RUN && stop_exec && !s_q.sysopt[0]
		|=> illegal_op_reset && mode == smpc_pkg::SMPC_RUN)
		else $error("disabled stop not trapped");
	AST_DEEPEXIT: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_DEEP && !reset_pin
		|=> mode == smpc_pkg::SMPC_DEEP)
		else $error("deep stop left without reset pin");
	AST_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		s_deep_wake |=> s_q.pmc2[2] && s_q.hold && por_reset)
		else $error("recovery flag not set on deep wake");
	AST_PERCLK: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_RUN && stop_exec && !dbg_halt_cmd
		&& s_q.sysopt[smpc_pkg::SMPC_B_STOP_INSTR_ENABLE]
		|=> !periph_clk_en && !cpu_clk_en)
		else $error("peripheral clock running in stop");
	AST_DBGCLK: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_RUN && stop_exec && s_q.sysopt[0] && dbg_on
		|=> dbg_clk_en && reg_full_on)
		else $error("debug clock or regulator dropped");
	AST_STATERR: assert property (@(posedge aclk) disable iff (!aresetn)
		in_light && dbg_cmd_valid && dbg_cmd_status
		|=> dbg_cmd_stop_err && !dbg_cmd_accept)
		else $error("status command not refused in stop");
	AST_HALTWAKE: assert property (@(posedge aclk) disable iff (!aresetn)
		in_light && s_q.dbg_keep && dbg_halt_cmd && !reset_pin
		|=> mode == smpc_pkg::SMPC_BGND ##1 1'b1)
		else $error("halt did not wake to background");
	AST_DEEPREG: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_DEEP |-> !reg_full_on && !core_power_on)
		else $error("regulator on in deep stop");
	AST_ACKOPEN: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ack_write
		|=> !s_q.hold && !s_q.pmc2[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_FLAG])
		else $error("ack write left latches shut");
	AST_ACKZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_en && wr_addr == smpc_pkg::SMPC_OFS_PMC2
		&& !wr_data[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_ACK]
		&& s_q.mode == smpc_pkg::SMPC_RUN && !stop_exec
		|=> $stable(s_q.hold)
		&& $stable(s_q.pmc2[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_FLAG]))
		else $error("zero ack write changed flag or latches");
	AST_ACKREAD: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_en && rd_addr == smpc_pkg::SMPC_OFS_PMC2
		|=> !s_axi_rdata[smpc_pkg::SMPC_B_PARTIAL_POWERDOWN_ACK])
		else $error("ack bit read back as one");
	AST_LVDTRIP: assert property (@(posedge aclk) disable iff (!aresetn)
		s_deep_wake |=> lvd_reset_en && lvd_low_trip)
		else $error("low voltage reset not armed on deep wake");
	AST_DEEPRST: assert property (@(posedge aclk) disable iff (!aresetn)
		s_deep_wake |=> s_q.clk1 == smpc_pkg::SMPC_RST_ZERO
		&& s_q.clk2 == smpc_pkg::SMPC_RST_ZERO
		&& s_q.dbg == smpc_pkg::SMPC_RST_ZERO
		&& s_q.sysopt == smpc_pkg::SMPC_RST_SYSOPT)
		else $error("control registers not reset on deep wake");
	AST_REGLVD: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_RUN && stop_exec && lvd_stop
		&& s_q.sysopt[smpc_pkg::SMPC_B_STOP_INSTR_ENABLE] |=> reg_full_on)
		else $error("regulator dropped with LVD kept in stop");
	AST_BGNDALL: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_BGND && dbg_cmd_valid
		|=> dbg_cmd_accept && !dbg_cmd_stop_err)
		else $error("command refused in background mode");
	AST_IRCOFF: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_LIGHT
		&& !(s_q.clk1[smpc_pkg::SMPC_B_IRCKEN]
		&& s_q.clk1[smpc_pkg::SMPC_B_IRSTEN]) |-> !irc_run)
		else $error("internal reference running without enables");
	AST_ADCOFF: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_LIGHT && !s_q.lvd_keep |-> !adc_run)
		else $error("converter running without LVD");
	AST_ERCHI: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_LIGHT && s_q.clk2[smpc_pkg::SMPC_B_RANGE]
		&& !s_q.lvd_keep |-> !erc_run)
		else $error("high range reference running without LVD");
	AST_DEEPPINS: assert property (@(posedge aclk) disable iff (!aresetn)
		mode == smpc_pkg::SMPC_DEEP |-> s_q.hold)
		else $error("pin latches open in deep stop");
	AST_LIGHTIRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		in_light && light_irq && !reset_pin
		&& !(dbg_halt_cmd && s_q.dbg_keep)
		|=> mode == smpc_pkg::SMPC_RUN && !por_reset)
		else $error("interrupt did not end light stop");
endmodule : smpc_top

// ---- verification/smpc_host_model.sv ----
// Model of the core and the debug host: STOP pulses and debug commands.
// Assumes calls from a single bench process in the aclk domain.
`timescale 1ns/100ps
module smpc_host_model (
	input  wire logic aclk,
	output logic      stop_exec,
	output logic      dbg_halt_cmd,
	output logic      dbg_cmd_valid,
	output logic      dbg_cmd_status,
	output logic      dbg_cmd_active
);
	initial begin
		stop_exec      = 1'b0;
		dbg_halt_cmd   = 1'b0;
		dbg_cmd_valid  = 1'b0;
		dbg_cmd_status = 1'b0;
		dbg_cmd_active = 1'b0;
	end
	// One-cycle pulse of {stop, halt, valid, status, active}
	task automatic send(input logic [4:0] v);
		@(posedge aclk);
		stop_exec      <= v[4];
		dbg_halt_cmd   <= v[3];
		dbg_cmd_valid  <= v[2];
		dbg_cmd_status <= v[1];
		dbg_cmd_active <= v[0];
		@(posedge aclk);
		// Qualifiers flip once released, so a stale type is never trusted
		stop_exec      <= 1'b0;
		dbg_halt_cmd   <= 1'b0;
		dbg_cmd_valid  <= 1'b0;
		dbg_cmd_status <= ~v[1];
		dbg_cmd_active <= ~v[0];
	endtask : send
endmodule : smpc_host_model

// ---- verification/tb_stop_mode_power_controller.sv ----
// Self-checking bench of the stop mode power controller.
// Assumes smpc_top and smpc_host_model; one 100 MHz clock.
`timescale 1ns/100ps
module tb_stop_mode_power_controller;
	logic        aclk = 1'b0, aresetn = 1'b0, reset_pin = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, wake_irq_lvd = 1'b0;
	logic        wake_irq_adc = 1'b0, wake_irq_sci = 1'b0;
	logic        wake_irq_pin = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [7:0]  port_out = 8'hA5, port_dir = 8'h3F, periph_own = 8'h00;
	logic [7:0]  periph_out = 8'h00, periph_dir = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, stop_exec, dbg_halt_cmd, dbg_cmd_valid;
	logic        dbg_cmd_status, dbg_cmd_active, dbg_cmd_accept;
	logic        dbg_cmd_stop_err, illegal_op_reset, por_reset;
	logic        periph_clk_en, dbg_clk_en, cpu_clk_en, reg_full_on;
	logic        core_power_on, ram_standby, adc_run, irc_run, erc_run;
	logic        lvd_reset_en, lvd_low_trip;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0]  pin_out, pin_oe;
	logic [3:0]  mode;
	logic [15:0] reset_vector;
	int          mismatches = 0, tests_run = 0, cycles = 0;

	smpc_top        dut_u (.*);
	smpc_host_model host_u (.*);

	always #5 aclk = ~aclk;
	// Ceiling far above the few hundred cycles the scenarios take
	always @(posedge aclk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = smpc_pkg::SMPC_RESP_OKAY);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = smpc_pkg::SMPC_RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {r, 24'h000000, d});
	endtask : rd

	task automatic t_reset();
		#1;
		chk(mode, smpc_pkg::SMPC_RUN);
		chk(reset_vector, smpc_pkg::SMPC_RESET_VECTOR);
		rd(smpc_pkg::SMPC_OFS_SYSOPT, smpc_pkg::SMPC_RST_SYSOPT);
		rd(smpc_pkg::SMPC_OFS_PMC1, smpc_pkg::SMPC_RST_PMC1);
		rd(8'h1C, 8'h00, smpc_pkg::SMPC_RESP_SLVERR);
		wr(8'h1C, 8'hFF, smpc_pkg::SMPC_RESP_SLVERR);
	endtask : t_reset

	task automatic t_illegal();
		// Lane 0 strobe low: the byte lands as zero, stop disabled
		s_axi_wstrb <= 4'hE;
		wr(smpc_pkg::SMPC_OFS_SYSOPT, 8'hFF);
		s_axi_wstrb <= 4'hF;
		rd(smpc_pkg::SMPC_OFS_SYSOPT, 8'h00);
		host_u.send(5'h10);
		#1;
		chk({mode, illegal_op_reset}, {smpc_pkg::SMPC_RUN, 1'b1});
		wr(smpc_pkg::SMPC_OFS_SYSOPT, 8'h01);
	endtask : t_illegal

	// ex holds {regulator, converter, internal ref, external ref}
	task automatic t_light(input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] c1, input logic [7:0] c2, input logic [4:0] wk,
		input logic [3:0] ex);
		wr(smpc_pkg::SMPC_OFS_PMC1, p1);
		wr(smpc_pkg::SMPC_OFS_PMC2, p2);
		wr(smpc_pkg::SMPC_OFS_CLK1, c1);
		wr(smpc_pkg::SMPC_OFS_CLK2, c2);
		host_u.send(5'h10);
		#1;
		chk(mode, smpc_pkg::SMPC_LIGHT);
		chk({periph_clk_en, cpu_clk_en, reg_full_on, adc_run, irc_run,
			erc_run}, {2'b00, ex});
		@(posedge aclk);
		reset_pin    <= wk[4];
		wake_irq_lvd <= wk[3];
		wake_irq_adc <= wk[2];
		wake_irq_sci <= wk[1];
		wake_irq_pin <= wk[0];
		@(posedge aclk);
		reset_pin    <= 1'b0;
		wake_irq_lvd <= 1'b0;
		wake_irq_adc <= 1'b0;
		wake_irq_sci <= 1'b0;
		wake_irq_pin <= 1'b0;
		#1;
		chk({mode, por_reset}, {smpc_pkg::SMPC_RUN, wk[4]});
	endtask : t_light

	task automatic t_debug();
		wr(smpc_pkg::SMPC_OFS_DBG, 8'h01);
		wr(smpc_pkg::SMPC_OFS_PMC1, 8'h01);
		wr(smpc_pkg::SMPC_OFS_PMC2, 8'h01);
		host_u.send(5'h10);
		#1;
		chk(mode, smpc_pkg::SMPC_LIGHT);
		chk({dbg_clk_en, reg_full_on, periph_clk_en}, 3'b110);
		host_u.send(5'h06);
		#1;
		chk({dbg_cmd_accept, dbg_cmd_stop_err}, 2'b01);
		host_u.send(5'h08);
		#1;
		chk(mode, smpc_pkg::SMPC_BGND);
		host_u.send(5'h05);
		#1;
		chk({dbg_cmd_accept, dbg_cmd_stop_err}, 2'b10);
		host_u.send(5'h06);
		#1;
		chk({dbg_cmd_accept, dbg_cmd_stop_err}, 2'b10);
		wr(smpc_pkg::SMPC_OFS_DBG, 8'h00);
		wr(smpc_pkg::SMPC_OFS_PMC2, 8'h01);
	endtask : t_debug

	task automatic t_deep();
		host_u.send(5'h10);
		#1;
		chk(mode, smpc_pkg::SMPC_DEEP);
		chk({core_power_on, ram_standby, reg_full_on, periph_clk_en},
			4'h4);
		@(posedge aclk);
		port_out <= 8'h3C;
		port_dir <= 8'hC3;
		wake_irq_sci <= 1'b1;
		// A halt command and an interrupt must both leave it asleep
		host_u.send(5'h08);
		wake_irq_sci <= 1'b0;
		#1;
		chk(mode, smpc_pkg::SMPC_DEEP);
		chk({pin_out, pin_oe}, 16'hA53F);
		@(posedge aclk);
		reset_pin <= 1'b1;
		@(posedge aclk);
		reset_pin <= 1'b0;
		#1;
		chk({mode, por_reset, lvd_reset_en, lvd_low_trip},
			{smpc_pkg::SMPC_RUN, 3'b111});
		chk({pin_out, pin_oe}, 16'hA53F);
		rd(smpc_pkg::SMPC_OFS_PMC2, 8'h04);
		rd(smpc_pkg::SMPC_OFS_CLK1, 8'h00);
		wr(smpc_pkg::SMPC_OFS_PMC2, 8'h00);
		rd(smpc_pkg::SMPC_OFS_PMC2, 8'h04);
		@(posedge aclk);
		periph_own <= 8'hF0;
		periph_out <= 8'h50;
		periph_dir <= 8'h80;
		wr(smpc_pkg::SMPC_OFS_PMC2, 8'h02);
		rd(smpc_pkg::SMPC_OFS_PMC2, 8'h00);
		#1;
		chk({pin_out, pin_oe}, 16'h5C83);
	endtask : t_deep

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_illegal();
		t_light(8'h03, 8'h01, 8'h03, 8'h0F, 5'h01, 4'hF);
		t_light(8'h03, 8'h00, 8'h02, 8'h08, 5'h02, 4'hC);
		t_light(8'h01, 8'h00, 8'h01, 8'h0F, 5'h04, 4'h0);
		t_light(8'h01, 8'h00, 8'h03, 8'h03, 5'h08, 4'h3);
		t_light(8'h03, 8'h00, 8'h03, 8'h07, 5'h10, 4'hB);
		t_debug();
		t_deep();
		end_of_test();
	end
endmodule : tb_stop_mode_power_controller
